/* File: bench/lsb_far_side.sv */
/*
 * Behavioural model of what stands outside the block: strap resistor and secondary
 * converter on the backup pin, LEDs tied to the supply on the indicator pins.
 * Assumes the block's pin drivers come as separate value and enable signals.
 */
`timescale 1ns/1ps

module lsb_far_side (
    input wire logic pin_oe,
    input wire logic pin_out,
    input wire logic strap_high,
    input wire logic [3:0] led_oe,
    input wire logic [3:0] led_out,
    output logic pin_level,
    output logic secondary_en,
    output logic [3:0] led_pad
);
    // ==========================================================
    // Backup pin
    // The strap resistor sets the level whenever the block lets the pin go.
    assign pin_level = pin_oe ? pin_out : strap_high;
    // The secondary converter is enabled only while the block drives the pin high.
    assign secondary_en = pin_oe & pin_level;

    // ==========================================================
    // Indicator pads
    // LEDs hang from the supply, so a released pad reads high.
    assign led_pad = (led_oe & led_out) | ~led_oe;
endmodule

/* File: bench/tb.sv */
/*
 * Self-checking bench for the link status and backup control block.
 * Assumes the design is built with short stretch and strap counts.
 */
`timescale 1ns/1ps

module tb;
    localparam int S = 8;
    localparam int T = 2;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic pecl = 1'b0, detect = 1'b0, rx_in = 1'b0, strap = 1'b0;
    logic req = 1'b0, mgmt_wr = 1'b0, mgmt_wdata = 1'b0;
    logic rx_data, rx_valid, pin_out, pin_oe, dis_bit, pin_level, sec_en;
    wire logic [3:0] led_oe, led_out, led_pad;
    lsb_pkg::lsb_media_status_s st [2];
    int tests_run = 0;
    int n_fail = 0;

    // ==========================================================
    // Clock and instances
    // One clock feeds all logic, stretch timers included.
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    initial
    begin
        st[0] = '0;
        st[1] = '0;
    end

    lsb_link_status #(.STRETCH_CYCLES(S), .STRAP_CYCLES(T)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .fiber_pecl_mode(pecl),
        .fiber_signal_detect_in(detect), .fiber_rx_data_in(rx_in),
        .fiber_rx_data(rx_data), .fiber_rx_valid(rx_valid),
        .backup_link_pin_in(pin_level), .backup_link_pin_out(pin_out),
        .backup_link_pin_oe(pin_oe), .backup_enable_req(req), .mgmt_wr(mgmt_wr),
        .mgmt_wdata(mgmt_wdata), .backup_disable_bit(dis_bit),
        .copper_status(st[0]), .fiber_status(st[1]),
        .copper_speed_indicator_out(led_out[0]), .copper_speed_indicator_oe(led_oe[0]),
        .fiber_speed_indicator_out(led_out[1]), .fiber_speed_indicator_oe(led_oe[1]),
        .copper_activity_indicator_out(led_out[2]),
        .copper_activity_indicator_oe(led_oe[2]),
        .fiber_activity_indicator_out(led_out[3]),
        .fiber_activity_indicator_oe(led_oe[3]));

    lsb_far_side far (.pin_oe(pin_oe), .pin_out(pin_out), .strap_high(strap),
        .led_oe(led_oe), .led_out(led_out), .pin_level(pin_level),
        .secondary_en(sec_en), .led_pad(led_pad));

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %b, wanted %b", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [3:0] exp_speed(input lsb_pkg::lsb_media_status_s s);
        return {2'b00, s.link_100 | s.link_10, s.link_100};
    endfunction

    // A write during the strap window must be ignored, so one is tried there.
    task automatic do_reset(input logic level);
        resetn = 1'b0;
        strap = level;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        mgmt_wr = 1'b1;
        mgmt_wdata = ~level;
        @(negedge sys_clk);
        mgmt_wr = 1'b0;
        repeat (T) @(negedge sys_clk);
        check({3'b000, dis_bit}, {3'b000, level});
        check({3'b000, pin_oe}, 4'h0);
        @(negedge sys_clk);
        check({3'b000, pin_oe}, 4'h1);
        $display("test strap %0d done", level);
    endtask

    // Runs one activity pattern and counts the cycles the pad is pulled low.
    task automatic act_run(input int side, input logic spd, input logic neg,
                           input logic pk, input int gap, input int exp);
        int n;
        n = 0;
        st[side] = '0;
        st[side].link_100 = spd;
        repeat (3) @(negedge sys_clk);
        for (int i = 0; i < 60; i++)
        begin
            if (i > 0 && led_oe[2 + side] === 1'b1 && led_pad[2 + side] === 1'b0)
                n++;
            st[side].neg_rx = neg && i < 4;
            st[side].packet = pk && (i == 0 || (gap != 0 && i == gap));
            @(negedge sys_clk);
        end
        check(n[3:0], exp[3:0]);
        st[side] = '0;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'h15b3));
        do_reset(1'b1);
        for (int i = 0; i < 4; i++)
        begin
            mgmt_wr = 1'b1;
            mgmt_wdata = i[0];
            req = i[1];
            @(negedge sys_clk);
            mgmt_wr = 1'b0;
            check({3'b000, dis_bit}, {3'b000, i[0]});
            @(negedge sys_clk);
            check({2'b00, pin_level, sec_en}, {2'b00, {2{i[1] & ~i[0]}}});
        end
        $display("test backup pin done");
        for (int i = 0; i < 40; i++)
        begin
            {pecl, detect, rx_in} = 3'($urandom());
            st[0] = 4'($urandom() & 32'hc);
            st[1] = 4'($urandom() & 32'hc);
            if (i == 0)
                {pecl, detect, rx_in, st[0], st[1]} = 11'h60c;
            @(negedge sys_clk);
            check({2'b00, rx_valid, rx_data},
                  {2'b00, ~pecl | detect, rx_in & (~pecl | detect)});
            check({2'b00, led_oe[0], led_out[0]}, exp_speed(st[0]));
            check({2'b00, led_oe[1], led_out[1]}, exp_speed(st[1]));
        end
        st[0] = '0;
        st[1] = '0;
        $display("test gate and speed done");
        for (int side = 0; side < 2; side++)
        begin
            act_run(side, 1'b1, 1'b0, 1'b1, 0, S);
            act_run(side, 1'b1, 1'b0, 1'b1, 3, S + 3);
            act_run(side, 1'b0, 1'b1, 1'b0, 0, 4);
            act_run(side, 1'b0, 1'b0, 1'b1, 0, 0);
            act_run(side, 1'b1, 1'b1, 1'b0, 0, 0);
        end
        $display("test activity done");
        do_reset(1'b0);
        tally_and_finish();
    end
endmodule

/* File: rtl/lsb_activity.sv */
/*
 * Activity indicator driver for one receive pair, with packet pulse stretching.
 * Assumes inputs synchronous to sys_clk and a registered speed-driven level.
 */
`timescale 1ns/1ps

module lsb_activity #(
    parameter int STRETCH_CYCLES = lsb_pkg::STRETCH_MIN_CYC
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic speed_driven,
    input wire logic neg_rx,
    input wire logic packet,
    output logic act_out,
    output logic act_oe
);

    // ==========================================================
    // Stretch counter
    localparam logic [lsb_pkg::STRETCH_CNT_W-1:0] LOAD =
        lsb_pkg::STRETCH_CNT_W'(STRETCH_CYCLES);
    localparam logic [lsb_pkg::STRETCH_CNT_W-1:0] ONE = lsb_pkg::STRETCH_CNT_W'(1);

    logic [lsb_pkg::STRETCH_CNT_W-1:0] cnt;
    logic next_oe;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt <= '0;
        end
        else if (!speed_driven)
        begin
            cnt <= '0;
        end
        else if (packet)
        begin
            cnt <= LOAD;
        end
        else if (cnt != '0)
        begin
            cnt <= cnt - 1'b1;
        end
    end

    // ==========================================================
    // Indicator drive
    always_comb
    begin
        if (!speed_driven)
        begin
            next_oe = neg_rx;
        end
        else
        begin
            // The pulse lasts exactly STRETCH_CYCLES, counting the last packet cycle.
            next_oe = packet || (cnt > ONE);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            act_oe <= 1'b0;
            act_out <= 1'b1;
        end
        else
        begin
            act_oe <= next_oe;
            act_out <= !next_oe;
        end
    end

    // ==========================================================
    // Checks
    a_neg_low_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
        !speed_driven && neg_rx |=> act_oe && !act_out)
        else $error("activity not low on negotiation");
    a_packet_low_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
        speed_driven && packet |=> act_oe && !act_out)
        else $error("activity not low on packet");
    a_stretch_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        STRETCH_CYCLES >= 8 && speed_driven && packet ##1 speed_driven [*7] |=> act_oe)
        else $error("activity pulse ended too early");
    a_release_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        speed_driven && !packet && cnt <= ONE |=> !act_oe)
        else $error("activity driven without cause");
    a_stretch_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
        speed_driven && packet |=> cnt == LOAD)
        else $error("stretch count not restarted");

    c_packet_seen: cover property (@(posedge sys_clk) disable iff (!resetn)
        speed_driven && packet ##1 !packet [*3]);
    c_neg_seen: cover property (@(posedge sys_clk) disable iff (!resetn)
        !speed_driven && neg_rx);

endmodule

/* File: rtl/lsb_link_status.sv */
/*
 * Top of the link status and backup control block: fiber receive gating,
 * power-up strap of the backup pin, speed and activity indicator drive.
 * Assumes all inputs synchronous to sys_clk; pads resolve the three-state pins.
 */
`timescale 1ns/1ps

// Function
// - In PECL mode fiber receive data passes only while signal detect is high.
// - At power-up the backup pin is sampled once into the backup disable bit.
// - A high strap sets the disable bit, turning the backup link off.
// - Management may overwrite the disable bit any time after power-up.
// - After power-up the backup pin becomes an active-high enable output.
// - Copper speed pin high at 100 Mbps, low at 10, otherwise released.
// - Fiber speed pin high at 100 Mbps, low at 10, otherwise released.
// - Copper speed released: copper activity low while negotiation signalling arrives.
// - Copper speed driven: copper activity low while a packet is detected.
// - Each copper packet indication is stretched to the minimum visible width.
// - Copper activity released when neither negotiation nor stretched packet applies.
// - Fiber activity follows the copper behaviour for the fiber pair.
// - All logic, stretch timers included, runs from the single reference clock.
module lsb_link_status #(
    parameter int STRETCH_CYCLES = lsb_pkg::STRETCH_MIN_CYC,
    parameter int STRAP_CYCLES = lsb_pkg::STRAP_DELAY_CYC
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic fiber_pecl_mode,
    input wire logic fiber_signal_detect_in,
    input wire logic fiber_rx_data_in,
    output logic fiber_rx_data,
    output logic fiber_rx_valid,
    input wire logic backup_link_pin_in,
    output logic backup_link_pin_out,
    output logic backup_link_pin_oe,
    input wire logic backup_enable_req,
    input wire logic mgmt_wr,
    input wire logic mgmt_wdata,
    output logic backup_disable_bit,
    input wire lsb_pkg::lsb_media_status_s copper_status,
    input wire lsb_pkg::lsb_media_status_s fiber_status,
    output logic copper_speed_indicator_out,
    output logic copper_speed_indicator_oe,
    output logic fiber_speed_indicator_out,
    output logic fiber_speed_indicator_oe,
    output logic copper_activity_indicator_out,
    output logic copper_activity_indicator_oe,
    output logic fiber_activity_indicator_out,
    output logic fiber_activity_indicator_oe
);

    // ==========================================================
    // Elaboration checks
    if (STRETCH_CYCLES < 2 || STRETCH_CYCLES > lsb_pkg::STRETCH_MAX_CYC)
    begin : g_bad_stretch
        $error("STRETCH_CYCLES out of range");
    end
    if (STRAP_CYCLES < 1 || STRAP_CYCLES >= (1 << lsb_pkg::STRAP_CNT_W))
    begin : g_bad_strap
        $error("STRAP_CYCLES out of range");
    end

    // ==========================================================
    // Fiber receive gating
    // Outside PECL mode the detect pin is unused, so data always passes.
    logic next_rx_valid;

    assign next_rx_valid = !fiber_pecl_mode || fiber_signal_detect_in;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fiber_rx_data <= 1'b0;
            fiber_rx_valid <= 1'b0;
        end
        else
        begin
            fiber_rx_valid <= next_rx_valid;
            fiber_rx_data <= next_rx_valid & fiber_rx_data_in;
        end
    end

    // ==========================================================
    // Backup pin strap and output
    localparam logic [lsb_pkg::STRAP_CNT_W-1:0] STRAP_LAST =
        lsb_pkg::STRAP_CNT_W'(STRAP_CYCLES - 1);

    lsb_pkg::lsb_backup_state_e bk_state;
    logic [lsb_pkg::STRAP_CNT_W-1:0] strap_cnt;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bk_state <= lsb_pkg::LSB_BK_WAIT;
            strap_cnt <= '0;
        end
        else
        begin
            case (bk_state)
                lsb_pkg::LSB_BK_WAIT:
                begin
                    strap_cnt <= strap_cnt + 1'b1;
                    if (strap_cnt == STRAP_LAST)
                    begin
                        bk_state <= lsb_pkg::LSB_BK_SAMPLE;
                    end
                end
                lsb_pkg::LSB_BK_SAMPLE:
                begin
                    bk_state <= lsb_pkg::LSB_BK_OUTPUT;
                end
                lsb_pkg::LSB_BK_OUTPUT:
                begin
                    bk_state <= lsb_pkg::LSB_BK_OUTPUT;
                end
                default:
                begin
                    bk_state <= lsb_pkg::LSB_BK_WAIT;
                end
            endcase
        end
    end

    // Writes arriving before the strap is taken are dropped: the strap owns the bit until then.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            backup_disable_bit <= lsb_pkg::BACKUP_DISABLE_RST;
        end
        else if (bk_state == lsb_pkg::LSB_BK_SAMPLE)
        begin
            backup_disable_bit <= backup_link_pin_in;
        end
        else if (bk_state == lsb_pkg::LSB_BK_OUTPUT && mgmt_wr)
        begin
            backup_disable_bit <= mgmt_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            backup_link_pin_oe <= 1'b0;
            backup_link_pin_out <= 1'b0;
        end
        else
        begin
            backup_link_pin_oe <= (bk_state == lsb_pkg::LSB_BK_OUTPUT);
            backup_link_pin_out <= (bk_state == lsb_pkg::LSB_BK_OUTPUT) &&
                backup_enable_req && !backup_disable_bit;
        end
    end

    // ==========================================================
    // Speed and activity indicators, one lane per receive pair
    lsb_pkg::lsb_media_status_s status [2];
    logic spd_out [2];
    logic spd_oe [2];
    logic act_out [2];
    logic act_oe [2];

    assign status[lsb_pkg::MEDIA_COPPER] = copper_status;
    assign status[lsb_pkg::MEDIA_FIBER] = fiber_status;

    for (genvar m = 0; m < 2; m++)
    begin : g_lane
        always_ff @(posedge sys_clk or negedge resetn)
        begin
            if (!resetn)
            begin
                spd_out[m] <= 1'b0;
                spd_oe[m] <= 1'b0;
            end
            else
            begin
                // A 100 Mbps indication wins if both are reported at once.
                spd_out[m] <= status[m].link_100;
                spd_oe[m] <= status[m].link_100 || status[m].link_10;
            end
        end

        lsb_activity #(
            .STRETCH_CYCLES(STRETCH_CYCLES)
        ) u_act (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .speed_driven(spd_oe[m]),
            .neg_rx(status[m].neg_rx),
            .packet(status[m].packet),
            .act_out(act_out[m]),
            .act_oe(act_oe[m])
        );
    end

    assign copper_speed_indicator_out = spd_out[lsb_pkg::MEDIA_COPPER];
    assign copper_speed_indicator_oe = spd_oe[lsb_pkg::MEDIA_COPPER];
    assign fiber_speed_indicator_out = spd_out[lsb_pkg::MEDIA_FIBER];
    assign fiber_speed_indicator_oe = spd_oe[lsb_pkg::MEDIA_FIBER];
    assign copper_activity_indicator_out = act_out[lsb_pkg::MEDIA_COPPER];
    assign copper_activity_indicator_oe = act_oe[lsb_pkg::MEDIA_COPPER];
    assign fiber_activity_indicator_out = act_out[lsb_pkg::MEDIA_FIBER];
    assign fiber_activity_indicator_oe = act_oe[lsb_pkg::MEDIA_FIBER];

    // ==========================================================
    // Checks
    a_fiber_gate_block: assert property (@(posedge sys_clk) disable iff (!resetn)
        fiber_pecl_mode && !fiber_signal_detect_in |=> !fiber_rx_valid && !fiber_rx_data)
        else $error("fiber data passed without signal detect");
    a_strap_load: assert property (@(posedge sys_clk) disable iff (!resetn)
        bk_state == lsb_pkg::LSB_BK_SAMPLE |=>
        backup_disable_bit == $past(backup_link_pin_in))
        else $error("strap not loaded");
    a_strap_high_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        bk_state == lsb_pkg::LSB_BK_SAMPLE && backup_link_pin_in |=> ##1 !backup_link_pin_out)
        else $error("backup enabled despite high strap");
    a_mgmt_overwrite: assert property (@(posedge sys_clk) disable iff (!resetn)
        bk_state == lsb_pkg::LSB_BK_OUTPUT && mgmt_wr |=>
        backup_disable_bit == $past(mgmt_wdata))
        else $error("management write lost");
    a_pin_output: assert property (@(posedge sys_clk) disable iff (!resetn)
        bk_state == lsb_pkg::LSB_BK_OUTPUT |=> backup_link_pin_oe &&
        backup_link_pin_out == ($past(backup_enable_req) && !$past(backup_disable_bit)))
        else $error("backup output wrong");
    a_pin_input: assert property (@(posedge sys_clk) disable iff (!resetn)
        bk_state == lsb_pkg::LSB_BK_WAIT |=> !backup_link_pin_oe)
        else $error("backup pin driven during strap");
    a_copper_speed: assert property (@(posedge sys_clk) disable iff (!resetn)
        copper_status.link_10 && !copper_status.link_100 |=>
        copper_speed_indicator_oe && !copper_speed_indicator_out)
        else $error("copper speed wrong at 10 Mbps");
    a_fiber_speed: assert property (@(posedge sys_clk) disable iff (!resetn)
        !fiber_status.link_10 && !fiber_status.link_100 |=> !fiber_speed_indicator_oe)
        else $error("fiber speed driven without signal");

    c_strap_high: cover property (@(posedge sys_clk) disable iff (!resetn)
        bk_state == lsb_pkg::LSB_BK_SAMPLE && backup_link_pin_in);
    c_backup_on: cover property (@(posedge sys_clk) disable iff (!resetn)
        backup_link_pin_oe && backup_link_pin_out);
    c_fiber_block: cover property (@(posedge sys_clk) disable iff (!resetn)
        fiber_pecl_mode && !fiber_signal_detect_in);

endmodule

/* File: rtl/lsb_pkg.sv */
/*
 * Shared constants and carrier types for the link status and backup control block.
 * Assumes a single 20 MHz system clock that stands in for the reference clock.
 */
package lsb_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int STRETCH_MIN_NS = 1300000;
    localparam int STRETCH_MAX_NS = 2700000;
    // A least time rounds up, a longest time rounds down.
    localparam int STRETCH_MIN_CYC = (STRETCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRETCH_MAX_CYC = STRETCH_MAX_NS / CLK_PERIOD_NS;
    localparam int STRETCH_CNT_W = 16;
    // The strap is read a few microseconds after power-up, once the pin has settled.
    localparam int STRAP_DELAY_NS = 2000;
    localparam int STRAP_DELAY_CYC = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_CNT_W = 8;

    // ==========================================================
    // Reset values and media lane indices
    localparam logic BACKUP_DISABLE_RST = 1'b0;
    localparam logic MEDIA_COPPER = 1'b0;
    localparam logic MEDIA_FIBER = 1'b1;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        LSB_BK_WAIT = 2'b00,
        LSB_BK_SAMPLE = 2'b01,
        LSB_BK_OUTPUT = 2'b10
    } lsb_backup_state_e;

    typedef struct packed {
        logic link_100;
        logic link_10;
        logic neg_rx;
        logic packet;
    } lsb_media_status_s;

endpackage
